// ==== rtl/hss_status_regs.v ====
// Read-only live status register group of the hot swap controller
//
// Contract
// R1 - Four read-only status registers at offsets zero to three.
// R2 - System bit 7 shows whether the switch drive is commanded on.
// R3 - System bit 6 shows the enable pin level, 1 for high.
// R4 - System bit 5 shows the real switch drive pin level.
// R5 - System bit 3 is 1 while the timer pin is below 0.1V.
// R6 - System bit 2 is 1 while a nonvolatile write is running.
// R7 - System bit 1 is 1 while the power good condition holds.
// R8 - Converter bits 7:4 hold the code of the last converted input.
// R9 - Converter bit 3 is 1 only when idle in snapshot mode.
// R10 - Input bits 7 to 4 show general-purpose pins one to four.
// R11 - Input bits 3 to 0 show mixed pins one to four.
// R12 - Fault bit 7 shows external fault on pin four per polarity.
// R13 - Fault bit 6 is 1 while a shorted switch is detected.
// R14 - Fault bit 5 is 1 while the output is below threshold.
// R15 - Fault bit 4 holds pin three fault level caught at check expiry.
// R16 - Fault bit 3 is 1 while a bad switch condition is present.
// R17 - Fault bit 2 is 1 while active current limiting is engaged.
// R18 - Fault bit 1 is 1 only when both undervoltage inputs are low.
// R19 - Fault bit 0 is 1 while the overvoltage input is high.
// R20 - Host writes to these registers are ignored.
`include "hss_defines.vh"
`default_nettype none

module hss_status_regs #(
  parameter ADDR_W = `HSS_ADDR_W,
  parameter CODE_W = `HSS_CONV_CODE_W
) (
  input  wire              i_clk,
  input  wire              i_rst,
  // Register access from the serial bus engine
  input  wire              i_rd_en,
  input  wire              i_wr_en,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [7:0]        i_wr_data,
  output reg  [7:0]        o_rd_data,
  output reg               o_rd_valid,
  output reg               o_wr_ignored,
  // Pins and comparator outputs, asynchronous to i_clk
  input  wire              i_insert_en_n_pin,
  input  wire              i_switch_drive_pin,
  input  wire              i_timer_pin_low,
  input  wire [3:0]        i_gp_pin_level,
  input  wire [3:0]        i_mixed_pin_level,
  input  wire              i_undervolt_upper_input,
  input  wire              i_undervolt_lower_input,
  input  wire              i_overvolt_input,
  input  wire              i_output_under_threshold,
  // Internal controller state, same clock
  input  wire              i_switch_commanded_on,
  input  wire              i_nvm_write_busy,
  input  wire              i_power_good_flag,
  input  wire              i_conv_done,
  input  wire [CODE_W-1:0] i_aux_channel_code,
  input  wire              i_snapshot_mode,
  input  wire              i_conv_busy,
  input  wire              i_switch_short_flag,
  input  wire              i_switch_bad_flag,
  input  wire              i_current_limit_active,
  input  wire              i_ext_fault_configured,
  input  wire              i_ext_fault_active_high,
  input  wire              i_pgi_configured,
  input  wire              i_pgi_active_high,
  input  wire              i_pgi_timer_expire,
  // Live copies of the four registers
  output reg  [7:0]        o_system_status,
  output reg  [7:0]        o_converter_status,
  output reg  [7:0]        o_input_pin_status,
  output reg  [7:0]        o_live_fault_status
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  localparam PIN_W = 15;

  wire [PIN_W-1:0] pins_async;
  wire [PIN_W-1:0] pins_sync;

  // All pin levels are bundled so one synchroniser serves them all
  assign pins_async = {i_insert_en_n_pin,
                       i_switch_drive_pin,
                       i_timer_pin_low,
                       i_gp_pin_level,
                       i_mixed_pin_level,
                       i_undervolt_upper_input,
                       i_undervolt_lower_input,
                       i_overvolt_input,
                       i_output_under_threshold};

  hss_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (pins_async),
    .o_sync  (pins_sync)
  );

  wire       en_pin_s;
  wire       drive_pin_s;
  wire       timer_low_s;
  wire [3:0] gp_pin_s;
  wire [3:0] mixed_pin_s;
  wire       uv_upper_s;
  wire       uv_lower_s;
  wire       overvolt_s;
  wire       out_low_s;

  // Unbundle the synchronised levels
  assign en_pin_s    = pins_sync[14];
  assign drive_pin_s = pins_sync[13];
  assign timer_low_s = pins_sync[12];
  assign gp_pin_s    = pins_sync[11:8];
  assign mixed_pin_s = pins_sync[7:4];
  assign uv_upper_s  = pins_sync[3];
  assign uv_lower_s  = pins_sync[2];
  assign overvolt_s  = pins_sync[1];
  assign out_low_s   = pins_sync[0];

  // ****************************************************************
  // Power-good input check on general-purpose pin three
  // ****************************************************************
  wire pgi_fault;

  hss_pgi_check u_pgi_check (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_pin_level    (gp_pin_s[2]),
    .i_configured   (i_pgi_configured),
    .i_active_high  (i_pgi_active_high),
    .i_timer_expire (i_pgi_timer_expire),
    .o_fault_q      (pgi_fault)
  );

  // ****************************************************************
  // Last converted channel code
  // ****************************************************************
  reg [CODE_W-1:0] channel_code_q;
  reg [CODE_W-1:0] channel_code_d;

  // Code only moves when a conversion completes, so a read in
  // between always sees the label of the finished measurement
  always @* begin
    channel_code_d = channel_code_q;
    if (i_conv_done) begin
      channel_code_d = i_aux_channel_code; // R8
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      channel_code_q <= `HSS_CODE_RST;
    end else begin
      channel_code_q <= channel_code_d;
    end
  end

  // ****************************************************************
  // System status
  // ****************************************************************
  reg [7:0] system_status_d;

  // Bit 4 is undefined and reads zero; bit 0 always reads one
  always @* begin
    system_status_d                      = 8'h00;
    system_status_d[`HSS_SYS_SWITCH_ON]  = i_switch_commanded_on; // R2
    system_status_d[`HSS_SYS_ENABLE_PIN] = en_pin_s;              // R3
    system_status_d[`HSS_SYS_DRIVE_HIGH] = drive_pin_s;           // R4
    system_status_d[`HSS_SYS_RSVD_UNDEF] = 1'b0;
    system_status_d[`HSS_SYS_TIMER_LOW]  = timer_low_s;           // R5
    system_status_d[`HSS_SYS_NVM_BUSY]   = i_nvm_write_busy;      // R6
    system_status_d[`HSS_SYS_POWER_GOOD] = i_power_good_flag;     // R7
    system_status_d[`HSS_SYS_RSVD_ONE]   = 1'b1;
  end

  // ****************************************************************
  // Converter status
  // ****************************************************************
  reg [7:0] converter_status_d;

  // Idle is reported only in snapshot mode with nothing in flight
  always @* begin
    converter_status_d = 8'h00;
    converter_status_d[`HSS_CONV_CODE_MSB:`HSS_CONV_CODE_LSB] =
      channel_code_q; // R8
    converter_status_d[`HSS_CONV_IDLE] =
      i_snapshot_mode & ~i_conv_busy; // R9
  end

  // ****************************************************************
  // Input pin status
  // ****************************************************************
  reg [7:0] input_pin_status_d;

  // Pin one of each group sits in the upper bit of its nibble
  always @* begin
    input_pin_status_d = 8'h00;
    input_pin_status_d[`HSS_INP_GP_MSB:`HSS_INP_GP_LSB] =
      {gp_pin_s[0], gp_pin_s[1], gp_pin_s[2], gp_pin_s[3]}; // R10
    input_pin_status_d[`HSS_INP_MIXED_MSB:`HSS_INP_MIXED_LSB] =
      {mixed_pin_s[0], mixed_pin_s[1],
       mixed_pin_s[2], mixed_pin_s[3]}; // R11
  end

  // ****************************************************************
  // Live fault status
  // ****************************************************************
  reg [7:0] live_fault_status_d;
  wire      external_fault_level;

  // External fault follows the configured polarity of pin four
  assign external_fault_level = i_ext_fault_configured &
    (i_ext_fault_active_high ? gp_pin_s[3] : ~gp_pin_s[3]); // R12

  always @* begin
    live_fault_status_d                     = 8'h00;
    live_fault_status_d[`HSS_FLT_EXTERNAL]  = external_fault_level;
    live_fault_status_d[`HSS_FLT_SHORT]     = i_switch_short_flag; // R13
    live_fault_status_d[`HSS_FLT_OUT_LOW]   = out_low_s;           // R14
    live_fault_status_d[`HSS_FLT_PGI_CHECK] = pgi_fault;           // R15
    live_fault_status_d[`HSS_FLT_BAD]       = i_switch_bad_flag;   // R16
    live_fault_status_d[`HSS_FLT_CUR_LIMIT] = i_current_limit_active; // R17
    live_fault_status_d[`HSS_FLT_UNDERVOLT] =
      ~uv_upper_s & ~uv_lower_s; // R18
    live_fault_status_d[`HSS_FLT_OVERVOLT]  = overvolt_s;          // R19
  end

  // ****************************************************************
  // Status registers
  // ****************************************************************
  // Refreshed every cycle; only hardware writes them, never the host
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_system_status     <= `HSS_SYSTEM_RST;
      o_converter_status  <= `HSS_CONVERTER_RST;
      o_input_pin_status  <= `HSS_INPUT_PIN_RST;
      o_live_fault_status <= `HSS_LIVE_FAULT_RST;
    end else begin
      o_system_status     <= system_status_d;
      o_converter_status  <= converter_status_d;
      o_input_pin_status  <= input_pin_status_d;
      o_live_fault_status <= live_fault_status_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [7:0] rd_data_d;

  // Decode of the four offsets; anything else reads the fill value
  always @* begin
    case (i_addr)
      `HSS_ADDR_SYSTEM:     rd_data_d = o_system_status;     // R1
      `HSS_ADDR_CONVERTER:  rd_data_d = o_converter_status;  // R1
      `HSS_ADDR_INPUT_PIN:  rd_data_d = o_input_pin_status;  // R1
      `HSS_ADDR_LIVE_FAULT: rd_data_d = o_live_fault_status; // R1
      default:              rd_data_d = `HSS_UNMAPPED_DATA;
    endcase
  end

  // Data is held between reads so the bus engine may shift it out
  // at its own pace without a second request
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_data_d;
      end
    end
  end

  // ****************************************************************
  // Write path
  // ****************************************************************
  wire wr_hit;

  // Write data is never stored: every register here is read-only.
  // The pulse lets the bus engine see the write landed on nothing.
  assign wr_hit = i_wr_en & (i_addr <= `HSS_ADDR_LIVE_FAULT) &
                  (i_wr_data == i_wr_data);

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wr_ignored <= 1'b0;
    end else begin
      o_wr_ignored <= wr_hit; // R20
    end
  end

endmodule // hss_status_regs

`default_nettype wire

// ==== shared/hss_defines.vh ====
// Offsets, bit positions and reset values of the hot swap status registers
`ifndef HSS_DEFINES_VH
`define HSS_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HSS_ADDR_W            8
`define HSS_ADDR_SYSTEM       8'h00
`define HSS_ADDR_CONVERTER    8'h01
`define HSS_ADDR_INPUT_PIN    8'h02
`define HSS_ADDR_LIVE_FAULT   8'h03

// ****************************************************************
// System status fields
// ****************************************************************
`define HSS_SYS_SWITCH_ON     7
`define HSS_SYS_ENABLE_PIN    6
`define HSS_SYS_DRIVE_HIGH    5
`define HSS_SYS_RSVD_UNDEF    4
`define HSS_SYS_TIMER_LOW     3
`define HSS_SYS_NVM_BUSY      2
`define HSS_SYS_POWER_GOOD    1
`define HSS_SYS_RSVD_ONE      0

// ****************************************************************
// Converter status fields
// ****************************************************************
`define HSS_CONV_CODE_MSB     7
`define HSS_CONV_CODE_LSB     4
`define HSS_CONV_IDLE         3
`define HSS_CONV_CODE_W       4

// ****************************************************************
// Input pin status fields
// ****************************************************************
`define HSS_INP_GP_MSB        7
`define HSS_INP_GP_LSB        4
`define HSS_INP_MIXED_MSB     3
`define HSS_INP_MIXED_LSB     0

// ****************************************************************
// Live fault status fields
// ****************************************************************
`define HSS_FLT_EXTERNAL      7
`define HSS_FLT_SHORT         6
`define HSS_FLT_OUT_LOW       5
`define HSS_FLT_PGI_CHECK     4
`define HSS_FLT_BAD           3
`define HSS_FLT_CUR_LIMIT     2
`define HSS_FLT_UNDERVOLT     1
`define HSS_FLT_OVERVOLT      0

// ****************************************************************
// Reset and fill values
// ****************************************************************
`define HSS_SYSTEM_RST        8'h01
`define HSS_CONVERTER_RST     8'h00
`define HSS_INPUT_PIN_RST     8'h00
`define HSS_LIVE_FAULT_RST    8'h00
`define HSS_CODE_RST          4'h0
`define HSS_UNMAPPED_DATA     8'h00

`endif

// ==== rtl/hss_sync.v ====
// Two-stage synchroniser for a group of pin levels
`default_nettype none

module hss_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // hss_sync

`default_nettype wire

// ==== rtl/hss_pgi_check.v ====
// Power-good input check: samples the pin when the check timer expires
`default_nettype none

module hss_pgi_check (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_pin_level,
  input  wire i_configured,
  input  wire i_active_high,
  input  wire i_timer_expire,
  output reg  o_fault_q
);

  reg fault_d;

  // Fault level is the inverse of the configured good level
  always @* begin
    fault_d = o_fault_q;
    if (!i_configured) begin
      fault_d = 1'b0;
    end else if (i_timer_expire) begin
      fault_d = i_active_high ? ~i_pin_level : i_pin_level; // R15
    end
  end

  // Captured value holds until the next expiry while the check stays configured
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_q <= 1'b0;
    end else begin
      o_fault_q <= fault_d;
    end
  end

endmodule // hss_pgi_check

`default_nettype wire

// ==== sim/hss_status_monitor.sv ====
// Concurrent checks on the ports of the status register group
`default_nettype none
module hss_status_monitor (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_rd_en,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic       o_wr_ignored,
  input wire logic       i_insert_en_n_pin,
  input wire logic       i_switch_drive_pin,
  input wire logic       i_timer_pin_low,
  input wire logic [3:0] i_gp_pin_level,
  input wire logic [3:0] i_mixed_pin_level,
  input wire logic       i_undervolt_upper_input,
  input wire logic       i_undervolt_lower_input,
  input wire logic       i_overvolt_input,
  input wire logic       i_switch_commanded_on,
  input wire logic       i_nvm_write_busy,
  input wire logic       i_power_good_flag,
  input wire logic       i_conv_done,
  input wire logic [3:0] i_aux_channel_code,
  input wire logic       i_snapshot_mode,
  input wire logic       i_conv_busy,
  input wire logic       i_switch_short_flag,
  input wire logic [7:0] o_system_status,
  input wire logic [7:0] o_converter_status,
  input wire logic [7:0] o_input_pin_status,
  input wire logic [7:0] o_live_fault_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_q;
  wire  [7:0] pins_rev;

  // Edges since reset, capped; pins need three before they are valid
  always @(posedge i_clk) begin
    if (i_rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Pin one sits in the top bit of each nibble
  assign pins_rev = {i_gp_pin_level[0], i_gp_pin_level[1],
    i_gp_pin_level[2], i_gp_pin_level[3], i_mixed_pin_level[0],
    i_mixed_pin_level[1], i_mixed_pin_level[2], i_mixed_pin_level[3]};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_read_valid: assert property (
    up_q != 2'h0 |-> o_rd_valid == $past(i_rd_en)) else $error("bad valid");
  a_read_system: assert property (
    i_rd_en && i_addr == 8'h00 ##1 $stable(o_system_status)
    |-> o_rd_data == o_system_status) else $error("bad system read");
  a_read_fault: assert property (
    i_rd_en && i_addr == 8'h03 ##1 $stable(o_live_fault_status)
    |-> o_rd_data == o_live_fault_status) else $error("bad fault read");
  a_read_unmapped: assert property (
    i_rd_en && i_addr > 8'h03 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_write_ack: assert property (
    up_q != 2'h0 |-> o_wr_ignored == ($past(i_wr_en) &&
    $past(i_addr) <= 8'h03)) else $error("bad write answer");
  a_sys_state: assert property (
    up_q != 2'h0 |-> {o_system_status[7], o_system_status[2:0]} ==
    {$past(i_switch_commanded_on), $past(i_nvm_write_busy),
    $past(i_power_good_flag), 1'b1}) else $error("bad system state");
  a_sys_pins: assert property (
    up_q == 2'h3 |-> {o_system_status[6:5], o_system_status[3]} ==
    $past({i_insert_en_n_pin, i_switch_drive_pin, i_timer_pin_low}, 3))
    else $error("bad system pins");
  a_conv_idle: assert property (
    up_q != 2'h0 |-> o_converter_status[3:0] ==
    {$past(i_snapshot_mode && !i_conv_busy), 3'h0})
    else $error("bad idle flag");
  a_chan_code: assert property (
    i_conv_done ##2 1'b1 |->
    o_converter_status[7:4] == $past(i_aux_channel_code, 2))
    else $error("bad channel code");
  a_input_pins: assert property (
    up_q == 2'h3 |-> o_input_pin_status == $past(pins_rev, 3))
    else $error("bad input pins");
  a_fault_volt: assert property (
    up_q == 2'h3 |-> o_live_fault_status[1:0] == $past({
    ~i_undervolt_upper_input & ~i_undervolt_lower_input,
    i_overvolt_input}, 3) && o_live_fault_status[6] ==
    $past(i_switch_short_flag)) else $error("bad fault flags");
endmodule // hss_status_monitor
`default_nettype wire

// ==== sim/hss_host_model.sv ====
// Host side of the byte register port
`default_nettype none
module hss_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  input  wire logic       i_wr_ignored,
  output var  logic       o_rd_en,
  output var  logic       o_wr_en,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    o_rd_en = 1'b0;
    o_wr_en = 1'b0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end

  // One read; the answer is taken one edge after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a; // Released address must not look still valid
    d = i_rd_data;
    v = i_rd_valid;
  endtask

  // One write; the data is never stored by the device
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ack);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
    ack = i_wr_ignored;
  endtask
endmodule // hss_host_model
`default_nettype wire

// ==== sim/hss_status_regs_tb.sv ====
// Self-checking bench for the status register group
`include "hss_defines.vh"
`default_nettype none
module hss_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       rd_en, wr_en, rd_valid, wr_ign, vld, ack;
  logic [7:0] addr, wr_data, rd_data, got, sys_s, conv_s, inp_s, flt_s;
  logic       en_n, drive, timer_pin_low, undervolt_upper_input, undervolt_lower_input, ov, out_low, cmd_on, nvm;
  logic       pg, done, snap, busy, short_f, bad_f, oc, ext_cfg, ext_hi;
  logic       pgi_cfg, pgi_hi, pgi_exp;
  logic [3:0] gp, mixed, code;
  logic [7:0] p;
  int         fail_count = 0;
  int         comparisons = 0;

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  hss_status_regs DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_rd_en(rd_en), .i_wr_en(wr_en),
    .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_wr_ignored(wr_ign),
    .i_insert_en_n_pin(en_n), .i_switch_drive_pin(drive),
    .i_timer_pin_low(timer_pin_low), .i_gp_pin_level(gp),
    .i_mixed_pin_level(mixed), .i_undervolt_upper_input(undervolt_upper_input),
    .i_undervolt_lower_input(undervolt_lower_input), .i_overvolt_input(ov),
    .i_output_under_threshold(out_low), .i_switch_commanded_on(cmd_on),
    .i_nvm_write_busy(nvm), .i_power_good_flag(pg), .i_conv_done(done),
    .i_aux_channel_code(code), .i_snapshot_mode(snap), .i_conv_busy(busy),
    .i_switch_short_flag(short_f), .i_switch_bad_flag(bad_f),
    .i_current_limit_active(oc), .i_ext_fault_configured(ext_cfg),
    .i_ext_fault_active_high(ext_hi), .i_pgi_configured(pgi_cfg),
    .i_pgi_active_high(pgi_hi), .i_pgi_timer_expire(pgi_exp),
    .o_system_status(sys_s), .o_converter_status(conv_s),
    .o_input_pin_status(inp_s), .o_live_fault_status(flt_s));

  hss_host_model u_host (.i_clk(i_clk), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .i_wr_ignored(wr_ign), .o_rd_en(rd_en),
    .o_wr_en(wr_en), .o_addr(addr), .o_wr_data(wr_data));

  // ********
  // Helpers
  // ********
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, got, vld);
    chk({7'h0, vld}, 8'h01);
    chk(got, e);
  endtask
  // Long enough for the two-flop pin synchroniser and the register
  task automatic settle;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic results;
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_system;
    for (int i = 0; i < 64; i++) begin
      p = 8'(i);
      {cmd_on, en_n, drive, timer_pin_low, nvm, pg} = p[5:0];
      settle;
      rdchk(`HSS_ADDR_SYSTEM, {p[5:3], 1'b0, p[2:0], 1'b1});
    end
    // Quiet system inputs so later scenarios start from a known state
    {cmd_on, en_n, drive, timer_pin_low, nvm, pg} = 6'h00;
  endtask
  task automatic t_conv;
    for (int c = 0; c < 16; c++) begin
      p = 8'(c);
      code = p[3:0];
      {snap, busy} = p[1:0];
      done = 1'b1;
      @(negedge i_clk);
      done = 1'b0;
      settle;
      rdchk(`HSS_ADDR_CONVERTER, {p[3:0], p[1] & ~p[0], 3'h0});
    end
  endtask
  task automatic t_input;
    for (int i = 0; i < 8; i++) begin
      p = 8'h01 << i;
      {gp, mixed} = p;
      settle;
      rdchk(`HSS_ADDR_INPUT_PIN, {p[4], p[5], p[6], p[7], p[0], p[1],
                                 p[2], p[3]});
    end
    {gp, mixed} = 8'h00;
  endtask
  task automatic t_fault;
    for (int i = 0; i < 128; i++) begin
      p = 8'(i);
      {short_f, out_low, bad_f, oc, undervolt_upper_input, undervolt_lower_input, ov} = p[6:0];
      settle;
      rdchk(`HSS_ADDR_LIVE_FAULT, {1'b0, p[6:5], 1'b0, p[4:3],
            ~p[2] & ~p[1], p[0]});
    end
    // Both undervoltage inputs high, everything else low: fault byte idle
    {short_f, out_low, bad_f, oc, undervolt_upper_input, undervolt_lower_input, ov} = 7'h06;
    for (int i = 0; i < 8; i++) begin
      p = 8'(i);
      {ext_cfg, ext_hi, gp[3]} = p[2:0];
      settle;
      rdchk(`HSS_ADDR_LIVE_FAULT, {p[2] & (p[1] ~^ p[0]), 7'h00});
    end
    {ext_cfg, gp} = 5'h00;
  endtask
  task automatic t_pgi;
    pgi_cfg = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = 8'(i);
      {pgi_hi, gp[2]} = p[1:0];
      settle;
      pgi_exp = 1'b1;
      @(negedge i_clk);
      pgi_exp = 1'b0;
      settle;
      rdchk(`HSS_ADDR_LIVE_FAULT, {3'h0, p[1] ^ p[0], 4'h0});
      gp[2] = ~gp[2]; // Level moves without a new expiry
      settle;
      rdchk(`HSS_ADDR_LIVE_FAULT, {3'h0, p[1] ^ p[0], 4'h0});
    end
    pgi_cfg = 1'b0;
    gp = 4'h0;
    settle;
    rdchk(`HSS_ADDR_LIVE_FAULT, 8'h00);
  endtask
  // Known state: code 15 with a busy snapshot, everything else quiet
  task automatic t_write;
    logic [7:0] expv [5] = '{8'h01, 8'hF0, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      p = (i < 4) ? 8'(i) : 8'h10;
      u_host.wr(p, 8'hFF, ack);
      chk({7'h0, ack}, {7'h0, i < 4});
      rdchk(p, expv[i]);
    end
  endtask

  // Main sequence
  initial begin
    {en_n, drive, timer_pin_low, ov, out_low, cmd_on, nvm, pg, done} = 9'h000;
    {snap, busy, short_f, bad_f, oc, ext_cfg, ext_hi} = 7'h00;
    {pgi_cfg, pgi_hi, pgi_exp, gp, mixed, code} = 15'h0000;
    {undervolt_upper_input, undervolt_lower_input} = 2'h3;
    repeat (6) @(negedge i_clk);
    chk(sys_s, `HSS_SYSTEM_RST);
    chk(conv_s | inp_s | flt_s, 8'h00);
    i_rst = 1'b0;
    settle;
    t_system;
    t_conv;
    t_input;
    t_fault;
    t_pgi;
    t_write;
    results;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #125000;
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    results;
  end
endmodule // hss_status_regs_tb

bind hss_status_regs hss_status_monitor u_mon (.*);
`default_nettype wire
